//--- rtl/bwd_defs.vh
`ifndef BWD_DEFS_VH
`define BWD_DEFS_VH

// =====================================
// register offsets
`define BWD_ADDR_W          12
`define BWD_OFF_ACTION      12'h1d3
`define BWD_OFF_PINCFG      12'hc47
`define BWD_OFF_TSCALE      12'hc65
`define BWD_OFF_TOVAL       12'hc66
`define BWD_OFF_TSTAT       12'hc68
`define BWD_OFF_IRQ_STAT    12'hc70
`define BWD_OFF_IRQ_MASK    12'hc71

// =====================================
// field positions
`define BWD_ACT_SEL_HI      5
`define BWD_ACT_SEL_LO      4
`define BWD_ACT_FLAG_BIT    7
`define BWD_TSCALE_SEC_BIT  7
`define BWD_TSTAT_FLAG_BIT  0
`define BWD_IRQ_EXPIRY_BIT  0
`define BWD_IRQ_ACTION_BIT  1

// =====================================
// action encodings
`define BWD_ACT_NONE        2'h0
`define BWD_ACT_COLD_RESET  2'h1
`define BWD_ACT_PWR_CYCLE   2'h2
`define BWD_ACT_PWR_OFF     2'h3

// =====================================
// reset values
`define BWD_RST_ACTION      8'h00
`define BWD_RST_PINCFG      8'h0e
`define BWD_RST_TSCALE      8'h08
`define BWD_RST_TOVAL       8'h00
`define BWD_RST_TSTAT       8'h00

// =====================================
// timing
`define BWD_CLK_HZ          20000000
`define BWD_SEC_PER_MIN     60
`define BWD_LAST_SEC_OF_MIN 6'h3b
`define BWD_PWR_OFF_SEC     3
`define BWD_COLD_RST_CYC    16

`endif

//--- rtl/bwd_tick.v
`timescale 1ns/1ps
`include "bwd_defs.vh"
// =====================================
// unit tick: one pulse per second, and one per minute
module bwd_tick #(
	parameter SEC_CYCLES = 20000000
) (
	// clock and control
	input  wire        core_clk,
	input  wire        srst,
	input  wire        clk_en,
	input  wire        restart,
	// ticks
	output reg         sec_tick,
	output reg         min_tick
);
	reg [31:0] cyc_q;
	reg [5:0]  sec_q;

	// restart aligns the unit boundary to the feed, so a feed grants a full unit
	always @(posedge core_clk) begin
		if (srst) begin
			cyc_q    <= 32'h0;
			sec_q    <= 6'h0;
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
		end else if (clk_en) begin
			sec_tick <= 1'b0;
			min_tick <= 1'b0;
			if (restart) begin
				cyc_q <= 32'h0;
				sec_q <= 6'h0;
			end else if (cyc_q == SEC_CYCLES - 1) begin
				cyc_q    <= 32'h0;
				sec_tick <= 1'b1;
				if (sec_q == `BWD_LAST_SEC_OF_MIN) begin
					sec_q    <= 6'h0;
					min_tick <= 1'b1;
				end else begin
					sec_q <= sec_q + 6'h1;
				end
			end else begin
				cyc_q <= cyc_q + 32'h1;
			end
		end
	end
endmodule

//--- rtl/bwd_action.v
`timescale 1ns/1ps
`include "bwd_defs.vh"
// =====================================
// action sequencer: drives reset and power controls once per expiry
module bwd_action #(
	parameter OFF_CYCLES = 60000000,
	parameter RST_CYCLES = 16
) (
	// clock and control
	input  wire        core_clk,
	input  wire        srst,
	input  wire        clk_en,
	// request
	input  wire        start,
	input  wire [1:0]  sel,
	// board controls
	output reg         cold_reset,
	output reg         power_en,
	output reg         busy
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RST  = 2'h1;
	localparam ST_OFF  = 2'h2;
	localparam ST_DEAD = 2'h3;

	reg [1:0]  st_q;
	reg [31:0] cnt_q;

	always @(posedge core_clk) begin
		if (srst) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 32'h0;
			cold_reset <= 1'b0;
			power_en   <= 1'b1;
			busy       <= 1'b0;
		end else if (clk_en) begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						cnt_q <= 32'h0;
						case (sel)
							`BWD_ACT_COLD_RESET: begin
								st_q       <= ST_RST;
								cold_reset <= 1'b1;
								busy       <= 1'b1;
							end
							`BWD_ACT_PWR_CYCLE: begin
								st_q     <= ST_OFF;
								power_en <= 1'b0;
								busy     <= 1'b1;
							end
							`BWD_ACT_PWR_OFF: begin
								st_q     <= ST_DEAD;
								power_en <= 1'b0;
								busy     <= 1'b1;
							end
							default: st_q <= ST_IDLE;
						endcase
					end
				end
				ST_RST: begin
					if (cnt_q == RST_CYCLES - 1) begin
						st_q       <= ST_IDLE;
						cold_reset <= 1'b0;
						busy       <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				ST_OFF: begin
					// power held off the full off time before coming back
					if (cnt_q == OFF_CYCLES - 1) begin
						st_q     <= ST_IDLE;
						power_en <= 1'b1;
						busy     <= 1'b0;
					end else begin
						cnt_q <= cnt_q + 32'h1;
					end
				end
				// power off is final until the board is reset
				ST_DEAD: st_q <= ST_DEAD;
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule

//--- rtl/bwd_top.v
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "bwd_defs.vh"
// Notes on behaviour
// - action bits 5:4 pick none, cold reset, power cycle or power off on expiry
// - power cycle keeps power off three seconds before restoring it
// - action register resets to zero: no action, flag clear
// - action register bit 7 reads one once a timeout has occurred
// - pin config resets to 0eh: watchdog enabled, push-pull, inverted
// - timescale bit 7 picks minutes when zero, seconds when one
// - timescale register resets to 08h
// - timeout value zero disables the watchdog; reset value is zero
// - timeout 01h to ffh arms; length is value plus one units
// - timer status reads zero while counting; resets to zero
// - timer flag reads 01h after expiry, holds until software clears it
module bwd_top #(
	parameter OFF_CYCLES = `BWD_PWR_OFF_SEC * `BWD_CLK_HZ,
	parameter SEC_CYCLES = `BWD_CLK_HZ
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        srst,
	input  wire        clk_en,
	// register port
	input  wire [11:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// board outputs
	output reg         watchdog_output_pin,
	output reg         cold_reset_q,
	output reg         power_en_q,
	output reg         irq_q
);
	// =====================================
	// registers
	reg [7:0] act_q;
	reg       act_flag_q;
	reg [7:0] pincfg_q;
	reg [7:0] tscale_q;
	reg [7:0] toval_q;
	reg       tflag_q;
	reg [8:0] count_q;
	reg [1:0] irq_stat_q;
	reg [1:0] irq_mask_q;
	reg       expire_q;

	wire      wr_toval = reg_wr && (reg_addr == `BWD_OFF_TOVAL);
	wire      sec_tick;
	wire      min_tick;
	wire      cold_rst;
	wire      pwr_en;

	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// =====================================
	// unit ticks
	bwd_tick #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.restart  (wr_toval),
		.sec_tick (sec_tick),
		.min_tick (min_tick)
	);

	wire unit_tick = tscale_q[`BWD_TSCALE_SEC_BIT] ? sec_tick : min_tick;
	wire armed     = (toval_q != 8'h00);
	wire expiry    = armed && (count_q == 9'h001) && unit_tick && !wr_toval;

	// =====================================
	// countdown and register writes
	always @(posedge core_clk) begin
		if (srst) begin
			act_q      <= `BWD_RST_ACTION;
			pincfg_q   <= `BWD_RST_PINCFG;
			tscale_q   <= `BWD_RST_TSCALE;
			toval_q    <= `BWD_RST_TOVAL;
			count_q    <= 9'h000;
			irq_mask_q <= 2'h0;
			expire_q   <= 1'b0;
		end else if (clk_en) begin
			expire_q <= expiry;
			if (reg_wr && hit(reg_addr, `BWD_OFF_ACTION))
				act_q <= reg_wdata;
			if (reg_wr && hit(reg_addr, `BWD_OFF_PINCFG))
				pincfg_q <= reg_wdata;
			if (reg_wr && hit(reg_addr, `BWD_OFF_TSCALE))
				tscale_q <= reg_wdata;
			if (reg_wr && hit(reg_addr, `BWD_OFF_IRQ_MASK))
				irq_mask_q <= reg_wdata[1:0];
			if (wr_toval) begin
				// feeding reloads with value plus one units
				toval_q <= reg_wdata;
				count_q <= {1'b0, reg_wdata} + 9'h001;
			end else if (armed && unit_tick && count_q != 9'h000) begin
				count_q <= count_q - 9'h001;
			end
		end
	end

	// =====================================
	// sticky flags: a set in the clearing cycle wins
	always @(posedge core_clk) begin
		if (srst) begin
			tflag_q    <= 1'b0;
			act_flag_q <= 1'b0;
			irq_stat_q <= 2'h0;
		end else if (clk_en) begin
			if (expiry)
				tflag_q <= 1'b1;
			else if (reg_wr && hit(reg_addr, `BWD_OFF_TSTAT) && reg_wdata[`BWD_TSTAT_FLAG_BIT])
				tflag_q <= 1'b0;
			if (expire_q)
				act_flag_q <= 1'b1;
			else if (reg_wr && hit(reg_addr, `BWD_OFF_ACTION) && reg_wdata[`BWD_ACT_FLAG_BIT])
				act_flag_q <= 1'b0;
			irq_stat_q <= (irq_stat_q & ~((reg_wr && hit(reg_addr, `BWD_OFF_IRQ_STAT))
				? reg_wdata[1:0] : 2'h0)) | {expire_q, expiry};
		end
	end

	// =====================================
	// action sequencer, started once per expiry
	bwd_action #(
		.OFF_CYCLES(OFF_CYCLES),
		.RST_CYCLES(`BWD_COLD_RST_CYC)
	) u_action (
		.core_clk   (core_clk),
		.srst       (srst),
		.clk_en     (clk_en),
		.start      (expire_q),
		.sel        (act_q[`BWD_ACT_SEL_HI:`BWD_ACT_SEL_LO]),
		.cold_reset (cold_rst),
		.power_en   (pwr_en),
		.busy       ()
	);

	// =====================================
	// outputs and read data
	always @(posedge core_clk) begin
		if (srst) begin
			watchdog_output_pin <= 1'b1;
			cold_reset_q        <= 1'b0;
			power_en_q          <= 1'b1;
			irq_q               <= 1'b0;
			reg_rdata           <= 8'h00;
		end else if (clk_en) begin
			// pin shows the flag inverted while bit 0 is clear, true while bit 0 is set; bit 3 enables the function
			watchdog_output_pin <= (pincfg_q[3] ? tflag_q : 1'b0) ^ pincfg_q[0] ^ 1'b1;
			cold_reset_q        <= cold_rst;
			power_en_q          <= pwr_en;
			irq_q               <= |(irq_stat_q & irq_mask_q);
			reg_rdata           <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`BWD_OFF_ACTION:   reg_rdata <= {act_flag_q, 1'b0, act_q[5:4], 4'h0};
					`BWD_OFF_PINCFG:   reg_rdata <= pincfg_q;
					`BWD_OFF_TSCALE:   reg_rdata <= tscale_q;
					`BWD_OFF_TOVAL:    reg_rdata <= toval_q;
					`BWD_OFF_TSTAT:    reg_rdata <= {7'h00, tflag_q};
					`BWD_OFF_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_q};
					`BWD_OFF_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_q};
					default:           reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

//--- dv/bwd_checker.sv
`timescale 1ns/1ps
// ====================
// port checker
module bwd_checker #(
	parameter OFF_CYCLES = 30
) (
	// clock and reset
	input wire        core_clk,
	input wire        srst,
	// register port
	input wire [11:0] reg_addr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	// board outputs
	input wire        watchdog_output_pin,
	input wire        cold_reset_q,
	input wire        power_en_q
);
	// run lengths of the reset pulse and the power gap
	reg [31:0] hi_q;
	reg [31:0] lo_q;
	always @(posedge core_clk) begin
		hi_q <= (srst || !cold_reset_q) ? 32'h0 : hi_q + 32'h1;
		lo_q <= (srst || power_en_q) ? 32'h0 : lo_q + 32'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property ($past(reg_rd) && !($past(reg_addr) inside
		{12'h1d3, 12'hc47, 12'hc65, 12'hc66, 12'hc68, 12'hc70, 12'hc71}) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_stat_bits: assert property ($past(reg_rd) && $past(reg_addr) == 12'hc68 |->
		reg_rdata[7:1] == 7'h00) else $error("status upper bits set");
	a_action_bits: assert property ($past(reg_rd) && $past(reg_addr) == 12'h1d3 |->
		reg_rdata[6] == 1'b0 && reg_rdata[3:0] == 4'h0) else $error("action spare bits set");
	a_reset_outs: assert property (disable iff (1'b0) srst |=>
		watchdog_output_pin && !cold_reset_q && power_en_q) else $error("reset outputs wrong");
	a_cold_len: assert property ($fell(cold_reset_q) && !$past(srst) |-> hi_q == 32'h10)
		else $error("cold reset pulse length");
	a_cycle_len: assert property ($rose(power_en_q) && !$past(srst) |-> lo_q == OFF_CYCLES)
		else $error("power off gap length");
	a_cold_power: assert property (cold_reset_q |-> power_en_q)
		else $error("power cut during cold reset");
	a_pin_action: assert property ($rose(cold_reset_q) || $fell(power_en_q) |->
		!watchdog_output_pin) else $error("action without pin");
endmodule
bind bwd_top bwd_checker #(.OFF_CYCLES(OFF_CYCLES)) u_chk (
	.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .watchdog_output_pin(watchdog_output_pin),
	.cold_reset_q(cold_reset_q), .power_en_q(power_en_q));

//--- dv/test_board_watchdog_with_reset_action.sv
`timescale 1ns/1ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_board_watchdog_with_reset_action;
	reg        core_clk = 1'b0;
	reg        srst = 1'b1;
	reg        ce = 1'b1;
	reg        rd = 1'b0;
	reg        wr = 1'b0;
	reg [11:0] ad = 12'h000;
	reg [7:0]  wd = 8'h00;
	reg [7:0]  lf = 8'h03;
	wire [7:0] rdat;
	wire       pin;
	wire       cold;
	wire       pwr;
	wire       irq;
	int        fails = 0;
	int        num_checks = 0;
	int        i;
	always #25 core_clk = ~core_clk;
	// shortened second and power gap keep the run brief
	bwd_top #(.OFF_CYCLES(30), .SEC_CYCLES(10)) dut (.core_clk(core_clk), .srst(srst),
		.clk_en(ce), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .watchdog_output_pin(pin), .cold_reset_q(cold),
		.power_en_q(pwr), .irq_q(irq));
	function [7:0] nxt(input [7:0] s);
		nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// cycles to expiry: value plus one units
	function int span(input [7:0] ts, input [7:0] v);
		span = (v + 1) * (ts[7] ? 10 : 600);
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wreg(input [11:0] a, input [7:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task rc(input [11:0] a, input [7:0] e);
		@(posedge core_clk);
		rd <= 1'b1;
		ad <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
		`CK(rdat, e)
	endtask
	task expire(input [7:0] ts, input [7:0] act, input [7:0] v);
		wreg(12'hc65, ts);
		wreg(12'h1d3, act);
		wreg(12'hc66, v);
		cyc(span(ts, v) - 5);
		rc(12'hc68, 8'h00);
		cyc(10);
		rc(12'hc68, 8'h01);
	endtask
	task clr;
		wreg(12'hc68, 8'h01);
		wreg(12'h1d3, 8'h80);
		wreg(12'hc70, 8'hff);
	endtask
	task end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		end_of_test;
	end
	initial begin
		cyc(5);
		srst <= 1'b0;
		rc(12'h1d3, 8'h00);
		rc(12'hc47, 8'h0e);
		rc(12'hc65, 8'h08);
		rc(12'hc66, 8'h00);
		rc(12'hc68, 8'h00);
		rc(12'h000, 8'h00);
		`CK(pin, 1'b1)
		for (i = 0; i < 4; i++) begin
			lf = nxt(lf);
			wreg(12'hc65, lf);
			rc(12'hc65, lf);
		end
		// a write while the clock enable is low must be ignored
		@(posedge core_clk);
		ce <= 1'b0;
		wreg(12'hc65, 8'h80);
		ce <= 1'b1;
		rc(12'hc65, lf);
		wreg(12'hc65, 8'h80);
		cyc(100);
		rc(12'hc68, 8'h00);
		$display("reset and disable done");
		wreg(12'hc71, 8'h01);
		rc(12'hc71, 8'h01);
		wreg(12'hc66, 8'h02);
		cyc(25);
		wreg(12'hc66, 8'h02);
		cyc(25);
		rc(12'hc68, 8'h00);
		// disarm so the fed count cannot expire inside the next setup
		wreg(12'hc66, 8'h00);
		expire(8'h80, 8'h10, 8'h02);
		`CK(cold, 1'b1)
		`CK(irq, 1'b1)
		rc(12'h1d3, 8'h90);
		rc(12'hc70, 8'h03);
		clr;
		rc(12'hc68, 8'h00);
		rc(12'h1d3, 8'h00);
		`CK(irq, 1'b0)
		$display("cold reset done");
		wreg(12'hc71, 8'h00);
		lf = nxt(lf);
		expire(8'h80, 8'h00, {5'h00, lf[2:0]} + 8'h01);
		`CK({irq, cold, pwr}, 3'b001)
		clr;
		expire(8'h80, 8'h20, 8'h01);
		`CK(pwr, 1'b0)
		cyc(40);
		`CK(pwr, 1'b1)
		clr;
		expire(8'h80, 8'h30, 8'h01);
		cyc(200);
		`CK(pwr, 1'b0)
		srst <= 1'b1;
		cyc(5);
		srst <= 1'b0;
		cyc(1);
		@(negedge core_clk);
		`CK(pwr, 1'b1)
		$display("power actions done");
		expire(8'h08, 8'h00, 8'h01);
		$display("minutes done");
		end_of_test;
	end
endmodule
